// file: hw/mb_ident_regs.svh
// Purpose: Constants for the serial identification and error responder.
// Assumes: Included by its bare name; holds definitions only.
// Notes: Byte values are frame field contents; times are in their own units.
`ifndef MB_IDENT_REGS_SVH
`define MB_IDENT_REGS_SVH
`define MB_FC_IDENT 8'h2b
`define MB_MEI_IDENT 8'h0e
`define MB_RC_SEQ 8'h01
`define MB_RC_ONE 8'h04
`define MB_CONFORMITY 8'h51
`define MB_ZERO_FIELD 8'h00
`define MB_LAST_OBJ 8'h02
`define MB_EXC_BIT 8'h80
`define MB_ERR_FUNC 8'h01
`define MB_ERR_ADDR 8'h02
`define MB_ERR_VALUE 8'h03
`define MB_CRC_INIT 16'hffff
`define MB_CRC_POLY 16'ha001
`define MB_CLK_PERIOD_NS 10
`define MB_CHAR_BITS 11
`define MB_GAP_TENTHS 35
`define MB_BAUD_DEFAULT 9600
`define MB_MIN_FRAME 4'h4
`define MB_HDR_IDENT_LEN 4'h8
`define MB_HDR_EXC_LEN 4'h3
`define MB_FW_LEN 4'h5
`define MB_FW_PREFIX 8'h56
`define MB_ASCII_ZERO 8'h30
`define MB_ASCII_DOT 8'h2e
`endif

// file: hw/mb_ident_pkg.sv
// Purpose: Types shared by the identification responder.
// Assumes: Constants come from mb_ident_regs.svh.
// Notes: Transmit sequencer states are binary coded.
package mb_ident_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_HDR = 3'b001,
      TX_CODE = 3'b010,
      TX_LEN = 3'b011,
      TX_VAL = 3'b100,
      TX_CRC_LO = 3'b101,
      TX_CRC_HI = 3'b110
   } tx_state_t;
endpackage

// file: hw/mb_byte_fifo.sv
// Purpose: Small valid/ready FIFO between the reply sequencer and the UART.
// Assumes: One clock, synchronous active-low reset.
// Notes: DEPTH must be a power of two so the pointers wrap naturally.
`timescale 1ns/100ps
module mb_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
         $error("FIFO depth must be a power of two of at least two");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////
   // Full and empty come straight from the occupancy count.
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and count update; a push and a pop together leave the count.
   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Storage needs no reset since empty slots are never shown.
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointer registers.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// file: hw/modbus_ident_and_error_responder.sv
// Purpose: Checks received serial frames and builds identification and exception replies.
// Assumes: A UART neighbour gives received bytes, parity flags and an end-of-frame pulse,
//          and takes reply bytes over valid/ready; all on core_clk.
// Notes: Normal replies for supported non-identification functions are left to other handlers; their exceptions are built here.
// Summary of operation
// [RULE1] Function 2Bh with MEI type 0Eh is a device identification read.
// [RULE2] Reply: address, function, MEI, read code, header fields, objects, CRC.
// [RULE3] Only basic objects 00 to 02 exist.
// [RULE4] Object values go out as ASCII, one byte per character; 00 is vendor.
// [RULE5] Object 01 is product code plus rated current, length set per model.
// [RULE6] Object 02 is firmware version as V, digit, dot, two digits.
// [RULE7] Read code 01 gives objects in sequence, 04 gives one object.
// [RULE8] Conformity 51h; more-follows and next-object are 00h.
// [RULE9] Act only on own address; stay silent on parity or CRC errors.
// [RULE10] Drop frame silently when an inter-byte gap exceeds 3.5 characters.
// [RULE11] Exceptions only follow a cleanly received frame with bad content.
// [RULE12] Unimplemented function answers error code 1.
// [RULE13] Nonexistent register or bit answers error code 2.
// [RULE14] Out-of-range written value answers error code 3.
// [RULE15] Writes to read-only, status or enable-locked items answer error 3.
// [RULE16] Command bit write without serial command source answers error 3.
// [RULE17] Exception: address, function with top bit set, error code, CRC.
// [RULE18] CRC-16 over all prior bytes, low byte sent first.
// [RULE19] Length byte equals character count; object above 02 answers error 2.
`timescale 1ns/100ps
`include "mb_ident_regs.svh"
module modbus_ident_and_error_responder #(
   parameter int BAUD = `MB_BAUD_DEFAULT,
   parameter int GAP_CYCLES = int'((`MB_GAP_TENTHS * `MB_CHAR_BITS * 64'd1000000000) /
                                   (64'd10 * BAUD * `MB_CLK_PERIOD_NS)),
   parameter int VENDOR_LEN = 6,
   parameter logic [127:0] VENDOR_STR = "VENDOR",
   parameter int PRODUCT_LEN = 10,
   parameter logic [127:0] PRODUCT_STR = "DRIVE 5.0A",
   parameter logic [3:0] FW_MAJOR = 4'h1,
   parameter logic [3:0] FW_TENTHS = 4'h0,
   parameter logic [3:0] FW_HUNDREDTHS = 4'h0,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] my_addr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_parity_err,
   input wire logic rx_frame_end,
   input wire logic func_supported,
   input wire logic data_addr_valid,
   input wire logic value_in_range,
   input wire logic target_writable,
   input wire logic cmd_src_serial,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic busy
);
   localparam int GW = $clog2(GAP_CYCLES + 2);
   localparam logic [GW-1:0] GAP_LIMIT = GW'(GAP_CYCLES);
   localparam logic [GW-1:0] GAP_MAX = GW'(GAP_CYCLES + 1);

   generate
      if (VENDOR_LEN < 1 || VENDOR_LEN > 16 || PRODUCT_LEN < 1 || PRODUCT_LEN > 16 ||
          FW_MAJOR > 4'h9 || FW_TENTHS > 4'h9 || FW_HUNDREDTHS > 4'h9 ||
          GAP_CYCLES < 1) begin : g_bad_param
         $error("Identification string or timing parameters out of range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // One byte step of the reflected CRC-16.
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Character count of an object.
   function automatic logic [7:0] obj_len(input logic [1:0] obj);
      case (obj)
         2'h0: obj_len = 8'(VENDOR_LEN);
         2'h1: obj_len = 8'(PRODUCT_LEN);
         default: obj_len = {4'h0, `MB_FW_LEN};
      endcase
   endfunction

   // Character idx of an object, first character first.
   function automatic logic [7:0] obj_char(input logic [1:0] obj, input logic [3:0] idx);
      logic [7:0] c;
      c = 8'h00;
      case (obj)
         2'h0: c = VENDOR_STR[8 * (VENDOR_LEN - 1 - int'(idx)) +: 8];
         2'h1: c = PRODUCT_STR[8 * (PRODUCT_LEN - 1 - int'(idx)) +: 8];
         default: begin
            case (idx)
               4'h0: c = `MB_FW_PREFIX;
               4'h1: c = `MB_ASCII_ZERO + {4'h0, FW_MAJOR};
               4'h2: c = `MB_ASCII_DOT;
               4'h3: c = `MB_ASCII_ZERO + {4'h0, FW_TENTHS};
               default: c = `MB_ASCII_ZERO + {4'h0, FW_HUNDREDTHS};
            endcase
         end
      endcase
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Receive side: byte count, running CRC, gap timer and the first fields.

   logic [3:0] rcnt_q, rcnt_d;
   logic [15:0] rcrc_q, rcrc_d;
   logic [GW-1:0] gap_q, gap_d;
   logic bad_q, bad_d;
   logic [7:0] fld_q [0:4];
   logic [7:0] fld_d [0:4];

   // Any parity error or overlong gap poisons the whole frame until its end.
   always_comb begin
      rcnt_d = rcnt_q;
      rcrc_d = rcrc_q;
      bad_d = bad_q;
      fld_d = fld_q;
      gap_d = (gap_q != GAP_MAX) ? gap_q + 1'b1 : gap_q;
      if (rx_frame_end) begin
         rcnt_d = 4'h0;
         rcrc_d = `MB_CRC_INIT;
         bad_d = 1'b0;
      end else if (rx_valid) begin
         if (rx_parity_err) begin
            bad_d = 1'b1; // [RULE9]
         end
         if (rcnt_q != 4'h0 && gap_q > GAP_LIMIT) begin
            bad_d = 1'b1; // [RULE10]
         end
         rcrc_d = crc_byte(rcrc_q, rx_data); // [RULE18]
         if (rcnt_q < 4'h5) begin
            fld_d[rcnt_q[2:0]] = rx_data;
         end
         if (rcnt_q != 4'hf) begin
            rcnt_d = rcnt_q + 1'b1;
         end
         gap_d = '0;
      end
   end

   // Receive registers.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rcnt_q <= 4'h0;
         rcrc_q <= `MB_CRC_INIT;
         gap_q <= '0;
         bad_q <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            fld_q[i] <= 8'h00;
         end
      end else begin
         rcnt_q <= rcnt_d;
         rcrc_q <= rcrc_d;
         gap_q <= gap_d;
         bad_q <= bad_d;
         fld_q <= fld_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame verdict, formed in the end-of-frame cycle.

   mb_ident_pkg::tx_state_t st_q, st_d;
   logic clean, launch, exc, ident;
   logic [7:0] err;

   // A frame over CRC that includes its own CRC bytes leaves a zero residue.
   assign clean = rx_frame_end && !bad_q && rcnt_q >= `MB_MIN_FRAME &&
                  rcrc_q == 16'h0000 && fld_q[0] == my_addr; // [RULE9] [RULE11]
   assign ident = (fld_q[1] == `MB_FC_IDENT);

   // Content checks in priority order; a non-identification request that passes is not ours.
   always_comb begin
      exc = 1'b1;
      err = `MB_ERR_FUNC;
      if (ident) begin
         if (fld_q[2] != `MB_MEI_IDENT) begin
            err = `MB_ERR_FUNC; // [RULE1] [RULE12]
         end else if (fld_q[3] != `MB_RC_SEQ && fld_q[3] != `MB_RC_ONE) begin
            err = `MB_ERR_VALUE; // [RULE7]
         end else if (fld_q[4] > `MB_LAST_OBJ) begin
            err = `MB_ERR_ADDR; // [RULE3] [RULE19]
         end else begin
            exc = 1'b0; // [RULE1]
         end
      end else if (!func_supported) begin
         err = `MB_ERR_FUNC; // [RULE12]
      end else if (!data_addr_valid) begin
         err = `MB_ERR_ADDR; // [RULE13]
      end else if (!value_in_range) begin
         err = `MB_ERR_VALUE; // [RULE14]
      end else if (!target_writable) begin
         err = `MB_ERR_VALUE; // [RULE15]
      end else if (!cmd_src_serial) begin
         err = `MB_ERR_VALUE; // [RULE16]
      end else begin
         exc = 1'b0; // Another handler answers a clean supported request.
      end
   end

   // A frame arriving while the sequencer is still building a reply is dropped.
   assign launch = clean && st_q == mb_ident_pkg::TX_IDLE && (ident || exc);

   ////////////////////////////////////////////////////////////////////////
   // Reply sequencer; it stalls whenever the FIFO is full.

   logic [7:0] addr_q, addr_d, func_q, func_d, err_q, err_d, rc_q, rc_d;
   logic exc_q, exc_d;
   logic [1:0] obj_q, obj_d, first_q, first_d, last_q, last_d;
   logic [3:0] idx_q, idx_d;
   logic [15:0] tcrc_q, tcrc_d;
   logic [7:0] cur;
   logic fifo_ready, push;

   // Byte currently offered to the FIFO.
   always_comb begin
      cur = 8'h00;
      case (st_q)
         mb_ident_pkg::TX_HDR: begin
            case (idx_q)
               4'h0: cur = addr_q;
               4'h1: cur = exc_q ? (func_q | `MB_EXC_BIT) : func_q; // [RULE17]
               4'h2: cur = exc_q ? err_q : `MB_MEI_IDENT; // [RULE2]
               4'h3: cur = rc_q;
               4'h4: cur = `MB_CONFORMITY; // [RULE8]
               4'h5: cur = `MB_ZERO_FIELD; // [RULE8]
               4'h6: cur = `MB_ZERO_FIELD;
               default: cur = {6'h00, last_q - first_q + 2'h1};
            endcase
         end
         mb_ident_pkg::TX_CODE: cur = {6'h00, obj_q};
         mb_ident_pkg::TX_LEN: cur = obj_len(obj_q); // [RULE19]
         mb_ident_pkg::TX_VAL: cur = obj_char(obj_q, idx_q); // [RULE4] [RULE5] [RULE6]
         mb_ident_pkg::TX_CRC_LO: cur = tcrc_q[7:0]; // [RULE18]
         mb_ident_pkg::TX_CRC_HI: cur = tcrc_q[15:8];
         default: cur = 8'h00;
      endcase
   end

   assign push = (st_q != mb_ident_pkg::TX_IDLE) && fifo_ready;

   // Sequencer next state.
   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      func_d = func_q;
      err_d = err_q;
      rc_d = rc_q;
      exc_d = exc_q;
      obj_d = obj_q;
      first_d = first_q;
      last_d = last_q;
      idx_d = idx_q;
      tcrc_d = tcrc_q;
      if (launch) begin
         st_d = mb_ident_pkg::TX_HDR;
         addr_d = fld_q[0];
         func_d = fld_q[1];
         err_d = err;
         rc_d = fld_q[3];
         exc_d = exc;
         obj_d = fld_q[4][1:0];
         first_d = fld_q[4][1:0];
         last_d = (fld_q[3] == `MB_RC_ONE) ? fld_q[4][1:0] : 2'h2; // [RULE7]
         idx_d = 4'h0;
         tcrc_d = `MB_CRC_INIT;
      end else if (push) begin
         if (st_q != mb_ident_pkg::TX_CRC_LO && st_q != mb_ident_pkg::TX_CRC_HI) begin
            tcrc_d = crc_byte(tcrc_q, cur); // [RULE18]
         end
         case (st_q)
            mb_ident_pkg::TX_HDR: begin
               idx_d = idx_q + 1'b1;
               if (idx_q == (exc_q ? `MB_HDR_EXC_LEN : `MB_HDR_IDENT_LEN) - 4'h1) begin
                  idx_d = 4'h0;
                  st_d = exc_q ? mb_ident_pkg::TX_CRC_LO : mb_ident_pkg::TX_CODE; // [RULE17]
               end
            end
            mb_ident_pkg::TX_CODE: st_d = mb_ident_pkg::TX_LEN;
            mb_ident_pkg::TX_LEN: st_d = mb_ident_pkg::TX_VAL;
            mb_ident_pkg::TX_VAL: begin
               idx_d = idx_q + 1'b1;
               if ({4'h0, idx_q} == obj_len(obj_q) - 8'h01) begin
                  idx_d = 4'h0;
                  if (obj_q == last_q) begin
                     st_d = mb_ident_pkg::TX_CRC_LO;
                  end else begin
                     obj_d = obj_q + 2'h1; // [RULE7]
                     st_d = mb_ident_pkg::TX_CODE;
                  end
               end
            end
            mb_ident_pkg::TX_CRC_LO: st_d = mb_ident_pkg::TX_CRC_HI;
            mb_ident_pkg::TX_CRC_HI: st_d = mb_ident_pkg::TX_IDLE;
            default: st_d = mb_ident_pkg::TX_IDLE;
         endcase
      end
   end

   // Sequencer registers.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_q <= mb_ident_pkg::TX_IDLE;
         addr_q <= 8'h00;
         func_q <= 8'h00;
         err_q <= 8'h00;
         rc_q <= 8'h00;
         exc_q <= 1'b0;
         obj_q <= 2'h0;
         first_q <= 2'h0;
         last_q <= 2'h0;
         idx_q <= 4'h0;
         tcrc_q <= `MB_CRC_INIT;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         func_q <= func_d;
         err_q <= err_d;
         rc_q <= rc_d;
         exc_q <= exc_d;
         obj_q <= obj_d;
         first_q <= first_d;
         last_q <= last_d;
         idx_q <= idx_d;
         tcrc_q <= tcrc_d;
      end
   end

   assign busy = (st_q != mb_ident_pkg::TX_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Reply bytes queue here so a slow UART simply stalls the sequencer.
   mb_byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(busy),
      .in_ready(fifo_ready),
      .in_data(cur),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
endmodule

// file: dv/resp_chk.sv
// Purpose: Port checker for the identification and error responder.
// Assumes: Bound to the responder top; one clock, synchronous active-low reset.
// Notes: Helper flags follow the frame in progress and clear at frame end.
`timescale 1ns/100ps
module resp_chk #(
   parameter int GAP_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] my_addr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_parity_err,
   input wire logic rx_frame_end,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic busy
);
   int gap_q;
   int cnt_q;
   logic par_q;
   logic late_q;
   logic [7:0] addr_q;
   ////////////////////////////////////////////////////////////////////////////////
   // The gap count saturates so a long idle line never wraps it back to small.
   always_ff @(posedge core_clk) begin
      if (!rst_b || rx_valid) begin
         gap_q <= 0;
      end else if (gap_q <= GAP_CYCLES) begin
         gap_q <= gap_q + 1;
      end
   end
   // Frame summary: byte count, parity, late bytes and the address byte.
   always_ff @(posedge core_clk) begin
      if (!rst_b || rx_frame_end) begin
         cnt_q <= 0;
         par_q <= 1'b0;
         late_q <= 1'b0;
      end else if (rx_valid) begin
         cnt_q <= cnt_q + 1;
         par_q <= par_q | rx_parity_err;
         late_q <= late_q | (cnt_q > 0 && gap_q > GAP_CYCLES);
         if (cnt_q == 0) begin
            addr_q <= rx_data;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   a_reset_idle: assert property (disable iff (1'b0) !rst_b |=> !tx_valid && !busy)
      else $error("outputs active after reset");
   a_busy_cause: assert property ($rose(busy) |-> $past(rx_frame_end))
      else $error("reply started without frame end");
   a_first_byte: assert property (
      $rose(busy) && !tx_valid |=> tx_valid && tx_data == my_addr)
      else $error("first reply byte late or not own address");
   a_data_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte changed before taken");
   a_push_busy: assert property ($rose(tx_valid) |-> $past(busy))
      else $error("reply byte without active reply");
   a_parity_drop: assert property (rx_frame_end && par_q |=> !$rose(busy))
      else $error("reply to frame with parity error");
   a_gap_drop: assert property (rx_frame_end && late_q |=> !$rose(busy))
      else $error("reply to frame with long gap");
   a_addr_drop: assert property (rx_frame_end && addr_q != my_addr |=> !$rose(busy))
      else $error("reply to foreign address");
   a_short_drop: assert property (rx_frame_end && cnt_q < 4 |=> !$rose(busy))
      else $error("reply to short frame");
endmodule
bind modbus_ident_and_error_responder resp_chk #(.GAP_CYCLES(GAP_CYCLES)) resp_chk_inst (
   .core_clk(core_clk), .rst_b(rst_b), .my_addr(my_addr), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_frame_end(rx_frame_end),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy)
);

// file: dv/master_model.sv
// Purpose: Serial master standing in for the link and UART side of the responder.
// Assumes: Drives one clean or poisoned frame per send call, 1 ns after each edge.
// Notes: The idle data line shows the inverse of the last byte, not a held value.
`timescale 1ns/100ps
module master_model (
   input wire logic core_clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_parity_err,
   output logic rx_frame_end,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic stall = 1'b0;
   mb_ident_pkg::byte_t got[$];
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_parity_err = 1'b0;
      rx_frame_end = 1'b0;
   end
   // A stalling consumer lets the reply FIFO fill up.
   assign tx_ready = !stall;
   always @(posedge core_clk) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
      end
   end
   // Whole frame, CRC already appended by the caller, then the end pulse.
   task automatic send(input mb_ident_pkg::byte_t f[$], input int bad, input int gap);
      foreach (f[i]) begin
         @(posedge core_clk);
         #1;
         rx_valid = 1'b1;
         rx_data = f[i];
         rx_parity_err = (i == bad);
         @(posedge core_clk);
         #1;
         rx_valid = 1'b0;
         rx_parity_err = 1'b0;
         rx_data = ~rx_data;
         repeat (gap) @(posedge core_clk);
      end
      @(posedge core_clk);
      #1;
      rx_frame_end = 1'b1;
      @(posedge core_clk);
      #1;
      rx_frame_end = 1'b0;
   endtask
endmodule

// file: dv/modbus_ident_and_error_responder_test.sv
// Purpose: Self-checking bench for the identification and error responder.
// Assumes: Gap limit shortened to 50 cycles; default strings VENDOR, DRIVE 5.0A, V1.00.
// Notes: Expected replies are built here, CRC included, from the frame layout.
`timescale 1ns/100ps
module modbus_ident_and_error_responder_test;
   typedef struct {
      logic [7:0] fn, mei, rc, obj;
      logic [4:0] ok;
      int code;
   } row_t;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] my_addr = 8'h01;
   logic func_supported = 1'b1;
   logic data_addr_valid = 1'b1;
   logic value_in_range = 1'b1;
   logic target_writable = 1'b1;
   logic cmd_src_serial = 1'b1;
   logic rx_valid, rx_parity_err, rx_frame_end, tx_valid, tx_ready, busy;
   logic [7:0] rx_data, tx_data;
   logic [7:0] f[$], e[$];
   int miscompares = 0;
   int tests_run = 0;
   // Code -1 is an identification reply, 0 silence, else the exception code.
   row_t rows [13] = '{'{8'h2b, 8'h0e, 8'h01, 8'h00, 5'h1f, -1},
      '{8'h2b, 8'h0e, 8'h01, 8'h01, 5'h1f, -1}, '{8'h2b, 8'h0e, 8'h01, 8'h02, 5'h1f, -1},
      '{8'h2b, 8'h0e, 8'h04, 8'h01, 5'h1f, -1}, '{8'h2b, 8'h0d, 8'h01, 8'h00, 5'h1f, 1},
      '{8'h2b, 8'h0e, 8'h02, 8'h00, 5'h1f, 3}, '{8'h2b, 8'h0e, 8'h04, 8'h03, 5'h1f, 2},
      '{8'h06, 8'h00, 8'h00, 8'h00, 5'h0f, 1}, '{8'h06, 8'h00, 8'h00, 8'h00, 5'h17, 2},
      '{8'h06, 8'h00, 8'h00, 8'h00, 5'h1b, 3}, '{8'h10, 8'h00, 8'h00, 8'h00, 5'h1d, 3},
      '{8'h05, 8'h00, 8'h00, 8'h00, 5'h1e, 3}, '{8'h03, 8'h00, 8'h00, 8'h00, 5'h1f, 0}};
   always #5 core_clk = ~core_clk;
   modbus_ident_and_error_responder #(.GAP_CYCLES(50)) modbus_ident_and_error_responder_inst (
      .core_clk(core_clk), .rst_b(rst_b), .my_addr(my_addr), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_frame_end(rx_frame_end),
      .func_supported(func_supported), .data_addr_valid(data_addr_valid),
      .value_in_range(value_in_range), .target_writable(target_writable),
      .cmd_src_serial(cmd_src_serial), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .busy(busy));
   master_model master_model_inst (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_parity_err(rx_parity_err), .rx_frame_end(rx_frame_end), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready));
   ////////////////////////////////////////////////////////////////////////////////
   // Reflected CRC-16, low byte first.
   function automatic void add_crc(ref logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endfunction
   task automatic frame(input logic [7:0] a, fn, b2, b3, b4);
      if (fn == 8'h2b) f = {a, fn, b2, b3, b4};
      else f = {a, fn, 8'h00, 8'h59, 8'h00, 8'h00};
      add_crc(f);
   endtask
   task automatic expect_reply(input logic [7:0] fn, rc, obj, input int code);
      string s;
      int last;
      e = {my_addr};
      last = (rc == 8'h04) ? int'(obj) : 2;
      if (code > 0) e = {e, fn | 8'h80, 8'(code)};
      else e = {e, fn, 8'h0e, rc, 8'h51, 8'h00, 8'h00, 8'(last - int'(obj) + 1)};
      for (int n = int'(obj); code < 0 && n <= last; n++) begin
         s = (n == 0) ? "VENDOR" : (n == 1) ? "DRIVE 5.0A" : "V1.00";
         e = {e, 8'(n), 8'(s.len())};
         for (int i = 0; i < s.len(); i++) e.push_back(s[i]);
      end
      if (code == 0) e = {};
      else add_crc(e);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits out the reply under a bound, then compares it byte for byte.
   task automatic finish();
      repeat (2) @(posedge core_clk);
      #1;
      for (int i = 0; i < 600 && (busy !== 1'b0 || tx_valid !== 1'b0); i++) begin
         @(posedge core_clk);
         #1;
      end
      chk("length", 8'(e.size()), 8'(master_model_inst.got.size()));
      foreach (e[i]) chk("byte", e[i], master_model_inst.got[i]);
   endtask
   task automatic go(input int bad, input int gap);
      master_model_inst.got.delete();
      master_model_inst.send(f, bad, gap);
      finish();
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Bounded run: a hang counts as a mismatch.
   initial begin
      #1000000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      foreach (rows[i]) begin
         {func_supported, data_addr_valid, value_in_range, target_writable, cmd_src_serial} =
            rows[i].ok;
         frame(8'h01, rows[i].fn, rows[i].mei, rows[i].rc, rows[i].obj);
         expect_reply(rows[i].fn, rows[i].rc, rows[i].obj, rows[i].code);
         go(-1, 0);
      end
      // Exact exception bytes for a write to a missing register.
      data_addr_valid = 1'b0;
      frame(8'h01, 8'h06, 8'h00, 8'h00, 8'h00);
      e = {8'h01, 8'h86, 8'h02, 8'hc3, 8'ha1};
      go(-1, 0);
      // Stalled consumer: the FIFO fills and a frame arriving meanwhile is dropped.
      expect_reply(8'h2b, 8'h01, 8'h00, -1);
      master_model_inst.got.delete();
      master_model_inst.stall = 1'b1;
      frame(8'h01, 8'h2b, 8'h0e, 8'h01, 8'h00);
      master_model_inst.send(f, -1, 0);
      repeat (20) @(posedge core_clk);
      #1;
      chk("stalled busy", 8'h01, {7'h00, busy});
      frame(8'h01, 8'h06, 8'h00, 8'h00, 8'h00);
      master_model_inst.send(f, -1, 0);
      master_model_inst.stall = 1'b0;
      finish();
      // Reset in mid reply clears busy and tx_valid.
      master_model_inst.stall = 1'b1;
      frame(8'h01, 8'h2b, 8'h0e, 8'h01, 8'h00);
      master_model_inst.send(f, -1, 0);
      repeat (5) @(posedge core_clk);
      #1;
      rst_b = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("reset idle", 8'h00, {6'h00, busy, tx_valid});
      rst_b = 1'b1;
      master_model_inst.stall = 1'b0;
      data_addr_valid = 1'b1;
      // Silent cases: foreign address, parity, long gap, CRC, short frame.
      e = {};
      my_addr = 8'h05;
      frame(8'h01, 8'h2b, 8'h0e, 8'h01, 8'h00);
      go(-1, 0);
      my_addr = 8'h01;
      go(2, 0);
      go(-1, 60);
      f[f.size() - 1] ^= 8'h01;
      go(-1, 0);
      f = {8'h01, 8'h2b, 8'h0e};
      go(-1, 0);
      // A gap well inside the limit is still accepted.
      frame(8'h01, 8'h2b, 8'h0e, 8'h04, 8'h02);
      expect_reply(8'h2b, 8'h04, 8'h02, -1);
      go(-1, 30);
      end_of_test();
   end
endmodule
